// file: verilog/chd_decode.sv
// decode and execute of high-register ops, pc-relative load and register-offset transfers
`default_nettype none
module chd_decode (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // instruction issue
  input wire logic issue_valid,
  input wire logic [15:0] issue_instr,
  input wire logic [31:0] issue_addr,
  output logic issue_ready,
  output logic issue_illegal,
  // register file read ports
  output logic [3:0] rd_a_idx,
  input wire logic [31:0] rd_a_data,
  output logic [3:0] rd_b_idx,
  input wire logic [31:0] rd_b_data,
  output logic [3:0] rd_c_idx,
  input wire logic [31:0] rd_c_data,
  // register file write
  output logic wr_en,
  output logic [3:0] wr_idx,
  output logic [31:0] wr_data,
  // status flags
  input wire logic [3:0] current_status_flags,
  output logic flags_wr,
  output logic [3:0] flags_new,
  // fetch and state
  output logic branch_taken,
  output logic [31:0] branch_target,
  output logic wide_state,
  // data memory
  output logic mem_req,
  output logic mem_we,
  output logic mem_byte,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // ************************************************************
  // field decode
  // ************************************************************
  logic is_hi, is_pcl, is_ro, dest_high_select, src_high_select, ld_bit, byte_bit;
  logic [1:0] group_opcode;
  logic [3:0] high_dest_reg, high_src_reg, base_reg, offset_reg, low_dest_reg;
  assign is_hi = issue_instr[15:10] == chd_pkg::HI_GROUP_TAG;
  assign is_pcl = issue_instr[15:11] == chd_pkg::PC_LOAD_TAG;
  assign is_ro = (issue_instr[15:12] == chd_pkg::REG_OFS_TAG) && !issue_instr[9];
  assign group_opcode = issue_instr[9:8];
  assign dest_high_select = issue_instr[7];
  assign src_high_select = issue_instr[6];
  assign high_dest_reg = {dest_high_select, issue_instr[2:0]};
  assign high_src_reg = {src_high_select, issue_instr[5:3]};
  assign base_reg = {1'b0, issue_instr[5:3]};
  assign offset_reg = {1'b0, issue_instr[8:6]};
  assign low_dest_reg = is_pcl ? {1'b0, issue_instr[10:8]} : {1'b0, issue_instr[2:0]};
  assign ld_bit = issue_instr[11];
  assign byte_bit = issue_instr[10];

  // ************************************************************
  // operands
  // ************************************************************
  logic [31:0] opa, opb, opc, pc_base, pc_plus, pcl_addr;
  chd_operand_port u_port_a (
    .idx(is_hi ? high_dest_reg : base_reg),
    .instr_addr(issue_addr),
    .rf_addr(rd_a_idx),
    .rf_data(rd_a_data),
    .value(opa)
  );
  chd_operand_port u_port_b (
    .idx(is_hi ? high_src_reg : offset_reg),
    .instr_addr(issue_addr),
    .rf_addr(rd_b_idx),
    .rf_data(rd_b_data),
    .value(opb)
  );
  chd_operand_port u_port_c (
    .idx(low_dest_reg),
    .instr_addr(issue_addr),
    .rf_addr(rd_c_idx),
    .rf_data(rd_c_data),
    .value(opc)
  );
  assign pc_plus = issue_addr + chd_pkg::PC_AHEAD;
  assign pc_base = {pc_plus[31:2], 1'b0, pc_plus[0]};
  assign pcl_addr = pc_base + {22'h0, issue_instr[7:0], 2'h0};

  logic [32:0] sum, diff;
  logic [3:0] cmp_flags;
  assign sum = {1'b0, opa} + {1'b0, opb};
  assign diff = {1'b0, opa} + {1'b0, ~opb} + 33'h0_0000_0001;
  always_comb begin
    cmp_flags = current_status_flags;
    cmp_flags[chd_pkg::FLAG_N] = diff[31];
    cmp_flags[chd_pkg::FLAG_Z] = diff[31:0] == 32'h0000_0000;
    cmp_flags[chd_pkg::FLAG_C] = diff[32];
    cmp_flags[chd_pkg::FLAG_V] = (opa[31] != opb[31]) && (diff[31] != opa[31]);
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  chd_pkg::chd_state_e state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt, after_r, after_nxt;
  logic ready_r, ready_nxt, illegal_r, illegal_nxt, wr_en_r, wr_en_nxt, flags_wr_r, flags_wr_nxt;
  logic br_r, br_nxt, wide_r, wide_nxt, mreq_r, mreq_nxt, mwe_r, mwe_nxt, mbyte_r, mbyte_nxt;
  logic [3:0] wr_idx_r, wr_idx_nxt, flags_r, flags_nxt;
  logic [31:0] wr_data_r, wr_data_nxt, bt_r, bt_nxt, maddr_r, maddr_nxt, mwdata_r, mwdata_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ready_nxt = ready_r;
    illegal_nxt = 1'b0;
    wr_en_nxt = 1'b0;
    wr_idx_nxt = wr_idx_r;
    wr_data_nxt = wr_data_r;
    flags_wr_nxt = 1'b0;
    flags_nxt = flags_r;
    br_nxt = 1'b0;
    bt_nxt = bt_r;
    wide_nxt = wide_r;
    mreq_nxt = mreq_r;
    mwe_nxt = mwe_r;
    mbyte_nxt = mbyte_r;
    maddr_nxt = maddr_r;
    mwdata_nxt = mwdata_r;
    after_nxt = after_r;
    case (state_r)
      chd_pkg::CHD_IDLE: begin
        ready_nxt = 1'b1;
        if (issue_valid && ready_r) begin
          ready_nxt = 1'b0;
          state_nxt = chd_pkg::CHD_WAIT;
          cnt_nxt = chd_pkg::CYC_ALU;
          if (is_hi) begin
            case (group_opcode)
              chd_pkg::OP_ADD: begin
                wr_en_nxt = 1'b1;
                wr_idx_nxt = high_dest_reg;
                wr_data_nxt = sum[31:0];
                if (high_dest_reg == chd_pkg::PC_INDEX) begin
                  br_nxt = 1'b1;
                  bt_nxt = {sum[31:1], 1'b0};
                  cnt_nxt = chd_pkg::CYC_PC_WRITE;
                end
              end
              chd_pkg::OP_CMP: begin
                flags_wr_nxt = 1'b1;
                flags_nxt = cmp_flags;
              end
              chd_pkg::OP_MOV: begin
                wr_en_nxt = 1'b1;
                wr_idx_nxt = high_dest_reg;
                wr_data_nxt = opb;
                if (high_dest_reg == chd_pkg::PC_INDEX) begin
                  br_nxt = 1'b1;
                  bt_nxt = {opb[31:1], 1'b0};
                  cnt_nxt = chd_pkg::CYC_PC_WRITE;
                end
              end
              default: begin
                if (dest_high_select) begin
                  illegal_nxt = 1'b1;
                end else begin
                  br_nxt = 1'b1;
                  bt_nxt = {opb[31:1], 1'b0};
                  wide_nxt = ~opb[0];
                  cnt_nxt = chd_pkg::CYC_PC_WRITE;
                end
              end
            endcase
          end else if (is_pcl || is_ro) begin
            state_nxt = chd_pkg::CHD_MEM;
            mreq_nxt = 1'b1;
            mwe_nxt = is_ro && !ld_bit;
            mbyte_nxt = is_ro && byte_bit;
            maddr_nxt = is_pcl ? pcl_addr : opa + opb;
            mwdata_nxt = byte_bit ? {24'h0, opc[7:0]} : opc;
            wr_idx_nxt = low_dest_reg;
            after_nxt = (is_ro && !ld_bit) ? 2'h0 : 2'h1;
          end else begin
            illegal_nxt = 1'b1;
            state_nxt = chd_pkg::CHD_DONE;
          end
        end
      end
      chd_pkg::CHD_MEM: begin
        if (mem_ack) begin
          mreq_nxt = 1'b0;
          state_nxt = chd_pkg::CHD_WAIT;
          // extra cycles keep store and load timing equal to the wide forms
          cnt_nxt = (after_r != 2'h0) ? chd_pkg::CYC_LOAD - 2'h1 : chd_pkg::CYC_STORE - 2'h1;
          if (after_r != 2'h0) begin
            wr_en_nxt = 1'b1;
            wr_data_nxt = mbyte_r ? {24'h0, mem_rdata[7:0]} : mem_rdata;
          end
        end
      end
      chd_pkg::CHD_WAIT: begin
        if (cnt_r <= 2'h1) begin
          state_nxt = chd_pkg::CHD_DONE;
        end else begin
          cnt_nxt = cnt_r - 2'h1;
        end
      end
      chd_pkg::CHD_DONE: begin
        state_nxt = chd_pkg::CHD_IDLE;
        ready_nxt = 1'b1;
      end
      default: begin
        state_nxt = chd_pkg::CHD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      state_r <= chd_pkg::CHD_IDLE;
      cnt_r <= 2'h0;
      ready_r <= 1'b0;
      illegal_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_idx_r <= 4'h0;
      wr_data_r <= 32'h0000_0000;
      flags_wr_r <= 1'b0;
      flags_r <= chd_pkg::RESET_FLAGS;
      br_r <= 1'b0;
      bt_r <= chd_pkg::RESET_PC;
      wide_r <= 1'b0;
      mreq_r <= 1'b0;
      mwe_r <= 1'b0;
      mbyte_r <= 1'b0;
      maddr_r <= 32'h0000_0000;
      mwdata_r <= 32'h0000_0000;
      after_r <= 2'h0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
      illegal_r <= illegal_nxt;
      wr_en_r <= wr_en_nxt;
      wr_idx_r <= wr_idx_nxt;
      wr_data_r <= wr_data_nxt;
      flags_wr_r <= flags_wr_nxt;
      flags_r <= flags_nxt;
      br_r <= br_nxt;
      bt_r <= bt_nxt;
      wide_r <= wide_nxt;
      mreq_r <= mreq_nxt;
      mwe_r <= mwe_nxt;
      mbyte_r <= mbyte_nxt;
      maddr_r <= maddr_nxt;
      mwdata_r <= mwdata_nxt;
      after_r <= after_nxt;
    end
  end

  assign issue_ready = ready_r;
  assign issue_illegal = illegal_r;
  assign wr_en = wr_en_r;
  assign wr_idx = wr_idx_r;
  assign wr_data = wr_data_r;
  assign flags_wr = flags_wr_r;
  assign flags_new = flags_r;
  assign branch_taken = br_r;
  assign branch_target = bt_r;
  assign wide_state = wide_r;
  assign mem_req = mreq_r;
  assign mem_we = mwe_r;
  assign mem_byte = mbyte_r;
  assign mem_addr = maddr_r;
  assign mem_wdata = mwdata_r;
endmodule // chd_decode
`default_nettype wire

// file: verilog/chd_pkg.sv
// package of constants for the compressed high-register, branch and load decode block
// Notes on behaviour
// - only compare in the high-register group updates flags; add, move, branch keep them.
// - opcode 00 adds source to destination and writes the sum back.
// - opcode 01 subtracts source from destination, drops result, sets flags.
// - opcode 10 copies source register into destination register.
// - opcode 11 with destination-high clear branches to address in source register.
// - branch target bit 0 picks state: 0 gives 32-bit, 1 gives compressed.
// - reading register 15 here yields instruction address plus 4, bit 0 cleared.
// - pc-relative load adds up to 255-word offset, loads word into low register.
// - pc-relative base is instruction address plus 4 with bit 1 cleared.
// - the 8-bit offset field counts words; byte offset is field shifted left 2.
// - register-offset transfers address base register plus offset register, both low.
// - store when load bit clear; byte bit picks word or low-byte store.
// - load when load bit set; byte bit picks word or single-byte load.
// - each instruction takes the same cycles as its 32-bit equivalent.
`default_nettype none
package chd_pkg;
  // ************************************************************
  // encodings
  // ************************************************************
  localparam logic [5:0] HI_GROUP_TAG = 6'h11;  // bits 15:10 = 010001
  localparam logic [4:0] PC_LOAD_TAG = 5'h09;   // bits 15:11 = 01001
  localparam logic [3:0] REG_OFS_TAG = 4'h5;    // bits 15:12 = 0101
  localparam logic [1:0] OP_ADD = 2'h0;
  localparam logic [1:0] OP_CMP = 2'h1;
  localparam logic [1:0] OP_MOV = 2'h2;
  localparam logic [1:0] OP_BX = 2'h3;
  localparam logic [3:0] PC_INDEX = 4'hf;
  localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
  localparam int WORD_SHIFT = 2;
  // flag bit positions in the flag vector {n,z,c,v}
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;
  // ************************************************************
  // cycle counts matching the 32-bit equivalents
  // ************************************************************
  localparam logic [1:0] CYC_ALU = 2'h1;
  localparam logic [1:0] CYC_PC_WRITE = 2'h3;
  localparam logic [1:0] CYC_STORE = 2'h2;
  localparam logic [1:0] CYC_LOAD = 2'h3;
  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam logic [3:0] RESET_FLAGS = 4'h0;
  typedef enum logic [3:0] {
    CHD_IDLE = 4'b0001,
    CHD_WAIT = 4'b0010,
    CHD_MEM = 4'b0100,
    CHD_DONE = 4'b1000
  } chd_state_e;
endpackage : chd_pkg
`default_nettype wire

// file: verilog/chd_operand_port.sv
// one register-file read port with the program counter substitution
`default_nettype none
module chd_operand_port (
  // selection
  input wire logic [3:0] idx,
  input wire logic [31:0] instr_addr,
  // register file read
  output logic [3:0] rf_addr,
  input wire logic [31:0] rf_data,
  // operand
  output logic [31:0] value
);
  logic [31:0] pc_val;
  assign rf_addr = idx;
  assign pc_val = instr_addr + chd_pkg::PC_AHEAD;
  always_comb begin
    if (idx == chd_pkg::PC_INDEX) begin
      value = {pc_val[31:1], 1'b0};
    end else begin
      value = rf_data;
    end
  end
endmodule // chd_operand_port
`default_nettype wire

// file: verification/chd_assertions.sv
// port checker of the compressed decode block
`default_nettype none
module chd_checker (
  // watched ports
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic issue_valid,
  input wire logic [15:0] issue_instr,
  input wire logic [31:0] issue_addr,
  input wire logic issue_ready,
  input wire logic issue_illegal,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic flags_wr,
  input wire logic branch_taken,
  input wire logic [31:0] branch_target,
  input wire logic wide_state,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic tk, hi, bx;
  logic [1:0] op;
  assign tk = clk_en && issue_valid && issue_ready;
  assign hi = issue_instr[15:10] == chd_pkg::HI_GROUP_TAG;
  assign op = issue_instr[9:8];
  assign bx = tk && hi && op == chd_pkg::OP_BX && !issue_instr[7];
  no_flag_a: assert property (
    tk && hi && op != chd_pkg::OP_CMP |=> !flags_wr) else $error("flags written");
  cmp_flag_a: assert property (
    tk && hi && op == chd_pkg::OP_CMP |=> flags_wr && !wr_en) else $error("compare lost");
  wr_dest_a: assert property (
    tk && hi && (op == chd_pkg::OP_ADD || op == chd_pkg::OP_MOV) |=> wr_en
    && wr_idx == {$past(issue_instr[7]), $past(issue_instr[2:0])}) else $error("bad dest");
  bx_go_a: assert property (
    bx |=> branch_taken && !branch_target[0]) else $error("branch missing");
  bx_bad_a: assert property (
    tk && hi && op == chd_pkg::OP_BX && issue_instr[7] |=> issue_illegal && !branch_taken)
    else $error("bad branch acted");
  state_src_a: assert property (
    $changed(wide_state) |-> $past(bx)) else $error("state changed");
  pc_base_a: assert property (
    tk && issue_instr[15:11] == chd_pkg::PC_LOAD_TAG |=> mem_req && !mem_we && mem_addr ==
    (($past(issue_addr) + 32'h4) & ~32'h2) + {$past(issue_instr[7:0]), 2'h0})
    else $error("pc load address");
  ro_kind_a: assert property (
    tk && issue_instr[15:12] == chd_pkg::REG_OFS_TAG && !issue_instr[9] |=> mem_req
    && mem_we == !$past(issue_instr[11]) && mem_byte == $past(issue_instr[10]))
    else $error("transfer kind");
  mem_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("request dropped");
  bstore_a: assert property (
    mem_req && mem_we && mem_byte |-> mem_wdata[31:8] == 24'h0) else $error("byte store");
  bload_a: assert property (
    clk_en && mem_req && mem_ack && !mem_we && mem_byte |=> wr_en
    && wr_data == {24'h0, $past(mem_rdata[7:0])}) else $error("byte load");
  alu_time_a: assert property (
    tk && hi && op == chd_pkg::OP_CMP ##1 clk_en [*2] |-> !issue_ready ##1 issue_ready)
    else $error("compare timing");
endmodule // chd_checker
bind chd_decode chd_checker i_chk (.sys_clk, .rst_n, .clk_en, .issue_valid, .issue_instr,
  .issue_addr, .issue_ready, .issue_illegal, .wr_en, .wr_idx, .wr_data, .flags_wr,
  .branch_taken, .branch_target, .wide_state, .mem_req, .mem_we, .mem_byte, .mem_addr,
  .mem_wdata, .mem_ack, .mem_rdata);
`default_nettype wire

// file: verification/chd_tb_top.sv
// self-checking bench of the compressed decode block
`default_nettype none
module compressed_hireg_branch_load_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, clk_en, issue_valid, issue_ready, issue_illegal, wr_en, flags_wr;
  logic branch_taken, wide_state, mem_req, mem_we, mem_byte, mem_ack, ce_q, mreq_q;
  logic [15:0] issue_instr;
  logic [31:0] issue_addr, rd_a_data, rd_b_data, rd_c_data, wr_data, branch_target;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, lfsr_q, r, a, dv, sv, df, v, ld_v;
  logic [3:0] rd_a_idx, rd_b_idx, rd_c_idx, wr_idx, current_status_flags, flags_new;
  logic [3:0] di, si;
  logic [4:0] ld_t;
  // byte flag and destination of each load, in issue order; the next issue may start before ack
  logic [4:0] lds [$];
  logic [31:0] rf [16];
  logic [71:0] notes [$];
  int miscompares, checks, dly;
  chd_decode i_dut (.sys_clk, .rst_n, .clk_en, .issue_valid, .issue_instr, .issue_addr,
    .issue_ready, .issue_illegal, .rd_a_idx, .rd_a_data, .rd_b_idx, .rd_b_data, .rd_c_idx,
    .rd_c_data, .wr_en, .wr_idx, .wr_data, .current_status_flags, .flags_wr, .flags_new,
    .branch_taken, .branch_target, .wide_state, .mem_req, .mem_we, .mem_byte, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata);
  assign rd_a_data = rf[rd_a_idx];
  assign rd_b_data = rf[rd_b_idx];
  assign rd_c_data = rf[rd_c_idx];
  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction
  function automatic logic [31:0] rv(input logic [3:0] i, input logic [31:0] pa);
    return i == 4'hf ? (pa + 32'h4) & ~32'h1 : rf[i];
  endfunction
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic see(input logic [71:0] o);
    chk(o, notes.size() ? notes.pop_front() : 72'h0);
  endtask
  task automatic issue(input logic [15:0] ins, input logic [31:0] ad);
    int n;
    n = 0;
    @(posedge sys_clk);
    issue_instr <= ins;
    issue_addr <= ad;
    issue_valid <= 1'h1;
    current_status_flags <= 4'(rnd());
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(issue_ready && clk_en) && n < 200);
    if (n >= 200) begin
      miscompares++;
      complete_run();
    end
    issue_valid <= 1'h0;
  endtask
  // ****
  // stimulus, stall and memory partner
  // ****
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // random stalls keep frozen pulses in play; the monitor counts only live cycles
  always @(posedge sys_clk) clk_en <= (rnd() & 32'h7) != 32'h0;
  always @(posedge sys_clk) ce_q <= clk_en;
  always @(posedge sys_clk) begin
    if (mem_ack) begin
      if (clk_en) begin
        mem_ack <= 1'h0;
        mem_rdata <= ~mem_rdata;
      end
    end else if (mem_req && dly > 0) dly <= dly - 1;
    else if (mem_req) begin
      ld_v = rnd();
      mem_ack <= 1'h1;
      mem_rdata <= ld_v;
      dly <= int'(rnd() & 32'h3);
      if (!mem_we) begin
        ld_t = lds.size() ? lds.pop_front() : 5'h0;
        notes.push_back({4'h1, ld_t[3:0], 32'h0, ld_t[4] ? {24'h0, ld_v[7:0]} : ld_v});
      end
    end
  end
  always @(negedge sys_clk) begin
    if (ce_q && wr_en) see({4'h1, wr_idx, 32'h0, wr_data});
    if (ce_q && wr_en) rf[wr_idx] = wr_data;
    if (ce_q && flags_wr) see({4'h2, flags_new, 64'h0});
    if (ce_q && branch_taken) see({4'h3, 3'h0, wide_state, 32'h0, branch_target});
    if (ce_q && issue_illegal) see({4'h5, 68'h0});
    if (mem_req && !mreq_q) begin
      see({4'h4, 2'h0, mem_we, mem_byte, mem_addr, mem_we ? mem_wdata : 32'h0});
    end
    mreq_q = mem_req;
  end
  initial begin
    {rst_n, clk_en, issue_valid, mem_ack, mreq_q, dly} = '0;
    {issue_instr, issue_addr, current_status_flags, mem_rdata} = '0;
    lfsr_q = 32'h0d2a;
    foreach (rf[i]) rf[i] = rnd();
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'h1;
    for (int op = 0; op < 3; op++) for (int h = 1; h < 4; h++) for (int k = 0; k < 2; k++) begin
      r = rnd();
      a = r & ~32'h1;
      di = {h[1], (h[1] && r[2:0] == 3'h7) ? 3'h6 : r[2:0]};
      si = {h[0], k ? 3'h7 : r[5:3]};
      issue({6'h11, op[1:0], h[1:0], si[2:0], di[2:0]}, a);
      dv = rv(di, a);
      sv = rv(si, a);
      df = dv - sv;
      if (op == 0) notes.push_back({4'h1, di, 32'h0, dv + sv});
      if (op == 1) notes.push_back({4'h2, df[31], df == 32'h0, dv >= sv,
        (dv[31] != sv[31]) && (df[31] != dv[31]), 64'h0});
      if (op == 2) notes.push_back({4'h1, di, 32'h0, sv});
    end
    $display("test high-register ops done");
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      si = {i[0], i[0] ? 3'h3 : r[2:0]};
      v = {r[31:1], i[1]};
      rf[si] = v;
      issue({6'h11, 2'h3, 1'h0, i[0], si[2:0], 3'h0}, r);
      notes.push_back({4'h3, 3'h0, !i[1], 32'h0, v & ~32'h1});
    end
    a = rnd() & ~32'h3;
    issue({6'h11, 2'h3, 2'h1, 3'h7, 3'h0}, a);
    notes.push_back({4'h3, 3'h0, 1'h1, 32'h0, a + 32'h4});
    issue({6'h11, 2'h3, 2'h2, 6'h0}, a);
    notes.push_back({4'h5, 68'h0});
    issue(16'h0000, a);
    notes.push_back({4'h5, 68'h0});
    $display("test branch exchange done");
    for (int i = 0; i < 2; i++) begin
      r = rnd();
      a = (r & ~32'h3) | 32'h2;
      issue({5'h09, r[10:8], i ? 8'hff : 8'h00}, a);
      lds.push_back({2'h0, r[10:8]});
      notes.push_back({4'h4, 4'h0, ((a + 32'h4) & ~32'h2) + (i ? 32'h3fc : 32'h0),
        32'h0});
    end
    $display("test pc load done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      issue({4'h5, i[1], i[0], 1'h0, r[8:6], r[5:3], r[2:0]}, a);
      if (i[1]) lds.push_back({i[0], 1'h0, r[2:0]});
      v = i[0] ? {24'h0, rf[r[2:0]][7:0]} : rf[r[2:0]];
      notes.push_back({4'h4, 2'h0, !i[1], i[0], rf[r[5:3]] + rf[r[8:6]],
        i[1] ? 32'h0 : v});
    end
    $display("test register offset done");
    repeat (40) @(posedge sys_clk);
    chk(72'(notes.size()), 72'h0);
    complete_run();
  end
endmodule // compressed_hireg_branch_load_decode_tb_top
`default_nettype wire
